// file: verilog/pld_pkg.sv
/*
 Package for the sum-of-products logic array: sizes, configuration row map,
 architecture word layout, mode codes, reset timing.
 Assumes a single 250 MHz core clock.
*/
package pld_pkg;
	localparam int NUM_INPUT_LINES   = 20;
	localparam int NUM_TERMS         = 64;
	localparam int TERMS_PER_GROUP   = 8;
	localparam int NUM_CELLS         = 8;
	localparam int ARRAY_ROWS        = 40;
	localparam int ROW_WIDTH         = 64;
	localparam int DEDICATED_INPUTS  = 12;
	localparam int ARCH_WIDTH        = 82;

	localparam logic [5:0] ROW_SIGNATURE  = 6'h28;
	localparam logic [5:0] ROW_RSVD_FIRST = 6'h29;
	localparam logic [5:0] ROW_RSVD_LAST  = 6'h3B;
	localparam logic [5:0] ROW_ARCH       = 6'h3C;
	localparam logic [5:0] ROW_SECURITY   = 6'h3D;
	localparam logic [5:0] ROW_ERASE      = 6'h3F;

	localparam int ARCH_POL_LSB  = 0;
	localparam int ARCH_CELL_LSB = 8;
	localparam int ARCH_MODE_BIT = 16;
	localparam int ARCH_GCFG_BIT = 17;

	typedef enum logic [1:0] {
		MODE_SIMPLE,
		MODE_COMPLEX,
		MODE_REGISTERED
	} mode_type;

	localparam int CLK_MHZ         = 250;
	localparam int RESET_TIME_US   = 10;
	localparam int RESET_CYCLES    = RESET_TIME_US * CLK_MHZ;
	localparam int RESET_CNT_WIDTH = 12;
endpackage : pld_pkg

// file: verilog/pld_output_macrocell_array.sv
/*
 Reprogrammable sum-of-products array with eight output macrocells and its
 configuration row store, reached over APB.
 Assumes the pins arrive synchronous to core_clk. The array clock pin is
 sampled and its rising edge clocks the macrocell registers.
*/
`timescale 1ns/10ps
module pld_output_macrocell_array
	import pld_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [11:0] data_in,
	input  wire logic        array_clk,
	input  wire logic        common_oe_n,
	input  wire logic [7:0]  cell_in,
	output logic      [7:0]  cell_out,
	output logic      [7:0]  cell_oe,
	output logic             power_up_done
);
	logic                   rst_sync1;
	logic                   rst_sync2;
	logic [ROW_WIDTH-1:0]   array_rows [ARRAY_ROWS];
	logic [ROW_WIDTH-1:0]   signature;
	logic [ARCH_WIDTH-1:0]  arch_word;
	logic                   security;
	logic [7:0]             cell_reg;
	logic                   clk_prev;
	logic [RESET_CNT_WIDTH-1:0] reset_count;
	logic [31:0]            next_prdata;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync1 <= 1'b0;
			rst_sync2 <= 1'b0;
		end else begin
			rst_sync1 <= 1'b1;
			rst_sync2 <= rst_sync1;
		end
	end

	// Word address: bits [7:2] row, bit 0 selects upper/lower 32 bits,
	// architecture row spans three words
	wire [5:0]  row_sel    = paddr[9:4];
	wire [1:0]  word_sel   = paddr[3:2];
	wire        setup_acc  = psel && !penable;
	wire        access     = psel && penable;
	wire        wr_acc     = access && pwrite;
	wire        is_array   = row_sel < 6'(ARRAY_ROWS);
	wire        is_sig     = row_sel == ROW_SIGNATURE;
	wire        is_rsvd    = row_sel >= ROW_RSVD_FIRST && row_sel <= ROW_RSVD_LAST;
	wire        is_arch    = row_sel == ROW_ARCH;
	wire        is_sec     = row_sel == ROW_SECURITY;
	wire        is_erase   = row_sel == ROW_ERASE;
	wire        unmapped   = is_rsvd || row_sel == 6'h3E || paddr[11:10] != 2'h0
		|| paddr[1:0] != 2'h0 || (!is_arch && word_sel[1]);
	wire        read_block = !pwrite && is_array && security;
	wire        bus_err    = unmapped || read_block;

	// Configuration fields
	wire [7:0]  polarity   = arch_word[ARCH_POL_LSB +: NUM_CELLS];
	wire [7:0]  cell_cfg   = arch_word[ARCH_CELL_LSB +: NUM_CELLS];
	wire        mode_bit   = arch_word[ARCH_MODE_BIT];
	wire        gcfg_bit   = arch_word[ARCH_GCFG_BIT];
	wire mode_type mode    = !mode_bit ? MODE_REGISTERED :
		(gcfg_bit ? MODE_COMPLEX : MODE_SIMPLE);

	// clock and enable pins as array inputs outside registered mode
	wire        spare_pins = mode != MODE_REGISTERED;
	wire [NUM_INPUT_LINES/2-1:0] line_true;
	assign line_true[3:0] = data_in[3:0];
	assign line_true[4]   = spare_pins ? array_clk : data_in[4];
	assign line_true[5]   = spare_pins ? common_oe_n : data_in[5];
	// Feedback from cells 2-5: registered ones feed back their register, others the pin
	genvar f;
	generate
		for (f = 0; f < 4; f++) begin : g_fb
			assign line_true[6+f] = (mode == MODE_REGISTERED && !cell_cfg[2+f])
				? cell_reg[2+f] : (cell_in[2+f] ^ data_in[6+f] ^ data_in[6+f]);
		end
	endgenerate
	// Connection bits 0-19 meet the true lines, 20-39 the complements
	wire [2*NUM_INPUT_LINES-1:0] lines = {{2{~line_true}}, {2{line_true}}};

	// AND matrix: bit t of row j connects line j into term t
	logic [NUM_TERMS-1:0] terms;
	genvar t;
	generate
		for (t = 0; t < NUM_TERMS; t++) begin : g_term
			wire [2*NUM_INPUT_LINES-1:0] conn;
			genvar r;
			for (r = 0; r < ARRAY_ROWS; r++) begin : g_conn
				assign conn[r] = array_rows[r][t];
			end
			assign terms[t] = &(~conn | lines);
		end
	endgenerate

	// groups of eight, data terms per cell
	logic [7:0] sum;
	logic [7:0] term_oe;
	logic [7:0] next_oe;
	logic [7:0] next_out;
	genvar c;
	generate
		for (c = 0; c < NUM_CELLS; c++) begin : g_cell
			wire [7:0] grp   = terms[c*TERMS_PER_GROUP +: TERMS_PER_GROUP];
			wire       regd  = mode == MODE_REGISTERED && !cell_cfg[c];
			wire       eight = regd || mode == MODE_SIMPLE;
			wire       outer = c == 0 || c == NUM_CELLS - 1;
			wire       centr = c == 3 || c == 4;
			assign sum[c]     = eight ? |grp : |grp[7:1];
			assign term_oe[c] = grp[0];
			// enable sources; in simple mode outputs always on and central cells never inputs
			assign next_oe[c] = regd ? !common_oe_n :
				(mode == MODE_SIMPLE ? (centr || !cell_cfg[c]) :
				// complex cells, outermost and inner alike, take the enable from their first term
				(mode == MODE_COMPLEX && outer ? term_oe[c] : term_oe[c]));
			// per-cell polarity: low bit means active low
			assign next_out[c] = regd ? ~cell_reg[c] : (sum[c] ^ ~polarity[c]);
		end
	endgenerate

	// power-up clear, outputs held off until count ends
	wire reset_busy = reset_count != RESET_CNT_WIDTH'(RESET_CYCLES - 1);
	always_ff @(posedge core_clk or negedge rst_sync2) begin
		if (!rst_sync2) begin
			reset_count   <= '0;
			power_up_done <= 1'b0;
		end else begin
			reset_count   <= reset_busy ? reset_count + 1'b1 : reset_count;
			power_up_done <= !reset_busy;
		end
	end

	wire clk_rise = array_clk && !clk_prev && mode == MODE_REGISTERED;
	always_ff @(posedge core_clk or negedge rst_sync2) begin
		if (!rst_sync2) begin
			clk_prev <= 1'b0;
			cell_reg <= 8'h00;
		end else begin
			clk_prev <= array_clk;
			if (clk_rise && !reset_busy)
				// Pin shows the inverse of the register, so store the inverse value
				cell_reg <= sum ^ polarity;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync2) begin
		if (!rst_sync2) begin
			cell_out <= 8'h00;
			cell_oe  <= 8'h00;
		end else begin
			cell_out <= next_out;
			cell_oe  <= reset_busy ? 8'h00 : next_oe;
		end
	end

	// Read mux; signature always readable
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (bus_err)
			next_prdata = 32'h0000_0000;
		else if (is_array)
			next_prdata = array_rows[row_sel][word_sel[0]*32 +: 32];
		else if (is_sig)
			next_prdata = signature[word_sel[0]*32 +: 32];
		else if (is_arch)
			next_prdata = word_sel == 2'h2 ? {14'h0000, arch_word[81:64]}
				: arch_word[word_sel[0]*32 +: 32];
		else if (is_sec)
			next_prdata = {31'h0000_0000, security};
	end

	// APB: one wait state, answer in the access phase second cycle
	always_ff @(posedge core_clk or negedge rst_sync2) begin
		if (!rst_sync2) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= access && !pready;
			prdata  <= (access && !pready) ? next_prdata : prdata;
			pslverr <= access && !pready && bus_err;
		end
	end

	wire commit = wr_acc && pready && !unmapped;
	integer i;
	always_ff @(posedge core_clk or negedge rst_sync2) begin
		if (!rst_sync2) begin
			for (i = 0; i < ARRAY_ROWS; i++)
				array_rows[i] <= '0;
			signature <= '0;
			arch_word <= '0;
			security  <= 1'b0;
		end else if (commit) begin
			if (is_erase) begin
				for (i = 0; i < ARRAY_ROWS; i++)
					array_rows[i] <= '0;
				signature <= '0;
				arch_word <= '0;
				security  <= 1'b0;
			end else if (is_array)
				array_rows[row_sel][word_sel[0]*32 +: 32] <= pwdata;
			else if (is_sig)
				signature[word_sel[0]*32 +: 32] <= pwdata;
			else if (is_arch && word_sel == 2'h2)
				arch_word[81:64] <= pwdata[17:0];
			else if (is_arch)
				arch_word[word_sel[0]*32 +: 32] <= pwdata;
			else if (is_sec && pwdata[0])
				// security only clears through bulk erase
				security <= 1'b1;
		end
	end
endmodule : pld_output_macrocell_array

// file: test/pld_array_chk.sv
/*
 Checker for the logic array: APB answer timing, refusals, power-up clear.
 Bound to the block; sees only its ports.
*/
`timescale 1ns/10ps
module pld_array_chk (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  cell_oe,
	input wire logic        power_up_done
);
	logic [11:0] wait_cnt;
	wire         rsvd = paddr[11:10] == 2'h0 && paddr[9:4] >= 6'h29 && paddr[9:4] <= 6'h3B;
	wire         sig  = paddr[11:3] == 9'h050 && paddr[1:0] == 2'h0;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			wait_cnt <= 12'h000;
		else if (!power_up_done && wait_cnt != 12'hFFF)
			wait_cnt <= wait_cnt + 12'h001;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_wait: assert property ($rose(penable) && psel |=> pready)
		else $error("answer not one cycle after access");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without answer");
	a_rsvd_error: assert property (pready && rsvd |-> pslverr)
		else $error("reserved row accepted");
	a_sig_open: assert property (pready && !pwrite && sig |-> !pslverr)
		else $error("signature read refused");
	a_oe_held: assert property (!power_up_done |-> cell_oe == 8'h00)
		else $error("pin driven before power-up clear");
	a_done_kept: assert property (power_up_done |=> power_up_done)
		else $error("power-up done dropped");
	a_clear_time: assert property (!power_up_done |-> wait_cnt < 12'hA28)
		else $error("power-up clear too slow");
	c_refused: cover property (pready && pslverr);
	c_cleared: cover property ($rose(power_up_done));
	c_some_oe: cover property (cell_oe != 8'h00 && cell_oe != 8'hFF);
endmodule : pld_array_chk
bind pld_output_macrocell_array pld_array_chk i_chk (.core_clk, .reset_n, .psel, .penable,
	.pwrite, .paddr, .pready, .pslverr, .cell_oe, .power_up_done);

// file: test/pld_board.sv
/*
 Board model on the macrocell pins: resolves each pin level.
 Assumes the bench chooses what the board drives on floated pins.
*/
`timescale 1ns/10ps
module pld_board (
	input wire logic       core_clk,
	input wire logic [7:0] cell_out,
	input wire logic [7:0] cell_oe,
	input wire logic [7:0] drive,
	input wire logic [7:0] drive_en,
	output logic     [7:0] cell_in
);
	logic [7:0] idle = 8'h55;
	// No pull resistor, so an undriven pin wanders every cycle
	always_ff @(posedge core_clk) idle <= ~idle;
	// floated pin taken from the board
	assign cell_in = (cell_oe & cell_out) | (~cell_oe & ((drive_en & drive) | (~drive_en & idle)));
endmodule : pld_board

// file: test/tb.sv
/*
 Bench for the logic array: config rows over APB, macrocell pins per mode.
 Assumes the board model on the pins; the checker is bound to the block.
*/
`timescale 1ns/10ps
module tb import pld_pkg::*;;
	logic        core_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0;
	logic        pwrite = 1'h0, array_clk = 1'h0, common_oe_n = 1'h0;
	logic        pready, pslverr, power_up_done, d;
	logic [11:0] paddr = 12'h000, data_in = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, sig_word;
	logic [7:0]  cell_in, cell_out, cell_oe, drive = 8'h00, drive_en = 8'h00;
	logic [33:0] notes[$], note;
	logic [11:0] bad[4] = '{12'h3E0, 12'h400, 12'h282, 12'h28C};
	logic [31:0] arch[3] = '{32'h0001_00FF, 32'h0001_0AFE, 32'h0003_FFFF};
	int          failures = 0, comparisons = 0;
	always #2 core_clk = ~core_clk;
	pld_output_macrocell_array i_dut (.core_clk, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .data_in, .array_clk,
		.common_oe_n, .cell_in, .cell_out, .cell_oe, .power_up_done);
	pld_board i_board (.core_clk, .cell_out, .cell_oe, .drive, .drive_en, .cell_in);
	task automatic check(input string what, input logic [31:0] x, input logic [31:0] got);
		comparisons++;
		if (got !== x) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, x, got);
		end
	endtask : check
	task automatic close_out;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w,
			input logic err, input logic [31:0] x);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= w;
		notes.push_back({~wr, err, x});
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// Pins are looked at three cycles on, past their update of one cycle, or two after an array clock edge
	task automatic pins(input logic [7:0] xo, input logic [7:0] xe);
		repeat (3) @(posedge core_clk);
		check("cell_oe", {24'h0, xe}, {24'h0, cell_oe});
		check("cell_out", {24'h0, xo & xe}, {24'h0, cell_out & xe});
	endtask : pins
	always @(posedge core_clk) if (pready === 1'h1) begin
		note = notes.pop_front();
		check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
		if (note[33])
			check("prdata", note[31:0], prdata);
	end
	initial begin
		sig_word = $urandom(32'h56DF);
		repeat (5) @(posedge core_clk);
		reset_n <= 1'h1;
		for (int i = 0; i < 2510 && power_up_done !== 1'h1; i++)
			@(posedge core_clk);
		check("power_up_done", 32'h1, {31'h0, power_up_done});
		apb(1'h1, {ROW_ARCH, 4'h0}, 32'h0, 1'h0, 32'h0);
		pins(8'hFF, 8'hFF);
		common_oe_n <= 1'h1;
		pins(8'hFF, 8'h00);
		apb(1'h1, {ROW_SIGNATURE, 4'h0}, sig_word, 1'h0, 32'h0);
		for (int r = 41; r < 60; r++)
			apb(1'h1, 12'(r * 16), 32'hFFFF_FFFF, 1'h1, 32'h0);
		foreach (bad[i])
			apb(1'h1, bad[i], 32'hFFFF_FFFF, 1'h1, 32'h0);
		apb(1'h1, 12'h000, 32'hFF, 1'h0, 32'h0);
		apb(1'h0, 12'h000, 32'h0, 1'h0, 32'hFF);
		apb(1'h1, {ROW_SECURITY, 4'h0}, 32'h1, 1'h0, 32'h0);
		apb(1'h0, 12'h000, 32'h0, 1'h1, 32'h0);
		apb(1'h0, {ROW_SIGNATURE, 4'h0}, 32'h0, 1'h0, sig_word);
		apb(1'h1, {ROW_ERASE, 4'h0}, 32'h0, 1'h0, 32'h0);
		apb(1'h0, 12'h000, 32'h0, 1'h0, 32'h0);
		apb(1'h0, {ROW_SIGNATURE, 4'h0}, 32'h0, 1'h0, 32'h0);
		apb(1'h1, 12'h000, 32'h7F, 1'h0, 32'h0);
		apb(1'h1, 12'h140, 32'h80, 1'h0, 32'h0);
		common_oe_n <= 1'h0;
		for (int m = 0; m < 3; m++) begin
			apb(1'h1, {ROW_ARCH, 4'h0}, arch[m], 1'h0, 32'h0);
			repeat (4) begin
				d = 1'($urandom);
				data_in <= {11'($urandom), d};
				drive <= 8'($urandom);
				drive_en <= 8'hFF;
				if (m == 2)
					pins(8'hFF, {7'h7F, d});
				else
					pins({7'h7F, m == 0}, m == 0 ? 8'hFF : 8'hFD);
			end
		end
		apb(1'h1, {ROW_ARCH, 4'h0}, 32'h0, 1'h0, 32'h0);
		pins(8'hFF, 8'hFF);
		array_clk <= 1'h1;
		pins(8'h00, 8'hFF);
		close_out;
	end
	initial begin
		#40000;
		failures++;
		close_out;
	end
endmodule : tb
